//--- design/pbg_top.sv
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ns
`include "pbg_map.svh"

module pbg_top
   import pbg_pkg::*;
#(
   parameter int ADDR_W = 18,
   parameter int WAKE_CYC = `PBG_WAKE_CYCLES
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [ADDR_W-1:0] wb_adr,
   input wire logic [3:0] wb_sel,
   input wire logic [31:0] wb_dat_w,
   output logic [31:0] wb_dat_r,
   output logic wb_ack,
   output logic wb_err,
   input wire logic [`PBG_NUM_PERIPH-1:0] periph_we_req,
   input wire logic [`PBG_NUM_PERIPH-1:0][7:0] periph_rdata_raw,
   input wire logic [`PBG_NUM_PERIPH-1:0][7:0] periph_rdata_init,
   output logic [`PBG_NUM_PERIPH-1:0] periph_clk_en,
   output logic [`PBG_NUM_PERIPH-1:0] periph_rst_n,
   output logic [`PBG_NUM_PERIPH-1:0] periph_we,
   output logic [`PBG_NUM_PERIPH-1:0][7:0] periph_rdata
);

   localparam int NP = `PBG_NUM_PERIPH;
   localparam int WW = ADDR_W - 2;

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------

   // Word index match; the low two address bits select a byte only
   function automatic logic idx_hit(input logic [WW-1:0] w, input logic [15:0] idx);
      return w == WW'(idx);
   endfunction

   // Byte register merged into lane 0 of the read word
   function automatic logic [31:0] lane0(input logic [7:0] b);
      return {24'h000000, b};
   endfunction

   // -----------------------------------------------------------------
   // Storage
   // -----------------------------------------------------------------
   logic [7:0] block_disable_0_reg, block_disable_0_next;
   logic [7:0] block_disable_1_reg, block_disable_1_next;
   logic [7:0] block_disable_2_reg, block_disable_2_next;
   logic [7:0] block_disable_3_reg, block_disable_3_next;
   logic [NP-1:0] dropped_reg, dropped_next;
   logic wb_ack_next;
   logic wb_err_next;
   logic [31:0] wb_dat_r_next;

   // -----------------------------------------------------------------
   // Bus decode
   // -----------------------------------------------------------------

   // One request per handshake: nothing is taken while an answer is out
   wire bus_req = wb_cyc & wb_stb;
   wire take = bus_req & ~wb_ack & ~wb_err;
   wire [WW-1:0] word = wb_adr[ADDR_W-1:2];
   wire hit_d0 = idx_hit(word, `PBG_IDX_DISABLE_0);
   wire hit_d1 = idx_hit(word, `PBG_IDX_DISABLE_1);
   wire hit_d2 = idx_hit(word, `PBG_IDX_DISABLE_2);
   wire hit_d3 = idx_hit(word, `PBG_IDX_DISABLE_3);
   wire hit_held = idx_hit(word, `PBG_IDX_HELD);
   wire hit_drop = idx_hit(word, `PBG_IDX_DROPPED);
   wire mapped = hit_d0 | hit_d1 | hit_d2 | hit_d3 | hit_held | hit_drop;

   // Disable registers live in byte lane 0; a disable write without that lane is a no-op
   wire wr_lane0 = take & wb_we & wb_sel[0];
   wire wr_d0 = wr_lane0 & hit_d0;
   wire wr_d1 = wr_lane0 & hit_d1;
   wire wr_d2 = wr_lane0 & hit_d2;
   wire wr_d3 = wr_lane0 & hit_d3;
   wire wr_drop = take & wb_we & hit_drop;

   // Drop-clear mask spans two lanes since there are more than eight gates
   wire [NP-1:0] drop_clr = wr_drop ? wb_dat_w[NP-1:0] & {{(NP-8){wb_sel[1]}}, {8{wb_sel[0]}}}
                                    : '0;

   // -----------------------------------------------------------------
   // Disable register next values
   // -----------------------------------------------------------------

   assign block_disable_0_next = wr_d0 ? wb_dat_w[7:0] : block_disable_0_reg;
   assign block_disable_1_next = wr_d1 ? wb_dat_w[7:0] : block_disable_1_reg;
   assign block_disable_2_next = wr_d2 ? wb_dat_w[7:0] : block_disable_2_reg;
   assign block_disable_3_next = wr_d3 ? wb_dat_w[7:0] : block_disable_3_reg;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         block_disable_0_reg <= `PBG_DISABLE_RST;
         block_disable_1_reg <= `PBG_DISABLE_RST;
         block_disable_2_reg <= `PBG_DISABLE_RST;
         block_disable_3_reg <= `PBG_DISABLE_RST;
      end else begin
         block_disable_0_reg <= block_disable_0_next;
         block_disable_1_reg <= block_disable_1_next;
         block_disable_2_reg <= block_disable_2_next;
         block_disable_3_reg <= block_disable_3_next;
      end
   end

   // -----------------------------------------------------------------
   // Named disable fields
   // -----------------------------------------------------------------

   wire timer_zero_off = block_disable_0_reg[`PBG_D0_TIMER_ZERO];
   wire timer_one_off = block_disable_0_reg[`PBG_D0_TIMER_ONE];
   wire timer_two_off = block_disable_0_reg[`PBG_D0_TIMER_TWO];
   wire timer_three_off = block_disable_0_reg[`PBG_D0_TIMER_THREE];
   wire capture_off = block_disable_1_reg[`PBG_D1_CAPTURE];
   wire khz_timer_off = block_disable_1_reg[`PBG_D1_KHZ_TIMER];
   wire pwm_off = block_disable_1_reg[`PBG_D1_PWM];
   wire i2c_off = block_disable_2_reg[`PBG_D2_I2C];
   wire uart_off = block_disable_2_reg[`PBG_D2_UART];
   wire sync_serial_off = block_disable_2_reg[`PBG_D2_SYNC_SERIAL];
   wire buzzer_off = block_disable_3_reg[`PBG_D3_BUZZER];

   // Gate vector in the package's peripheral order
   wire [NP-1:0] off_vec;
   assign off_vec[PBG_P_TIMER_ZERO] = timer_zero_off;
   assign off_vec[PBG_P_TIMER_ONE] = timer_one_off;
   assign off_vec[PBG_P_TIMER_TWO] = timer_two_off;
   assign off_vec[PBG_P_TIMER_THREE] = timer_three_off;
   assign off_vec[PBG_P_CAPTURE] = capture_off;
   assign off_vec[PBG_P_KHZ_TIMER] = khz_timer_off;
   assign off_vec[PBG_P_PWM] = pwm_off;
   assign off_vec[PBG_P_I2C] = i2c_off;
   assign off_vec[PBG_P_UART] = uart_off;
   assign off_vec[PBG_P_SYNC_SERIAL] = sync_serial_off;
   assign off_vec[PBG_P_BUZZER] = buzzer_off;

   // -----------------------------------------------------------------
   // Per-peripheral gates
   // -----------------------------------------------------------------
   wire [NP-1:0] held_vec;

   for (genvar g = 0; g < NP; g++) begin : g_gate
      pbg_gate #(
         .WAKE_CYC(WAKE_CYC)
      ) u_gate (
         .clk(clk),
         .arst_n(arst_n),
         .off(off_vec[g]),
         .we_req(periph_we_req[g]),
         .rdata_raw(periph_rdata_raw[g]),
         .rdata_init(periph_rdata_init[g]),
         .clk_en_reg(periph_clk_en[g]),
         .rst_n_reg(periph_rst_n[g]),
         .we_reg(periph_we[g]),
         .rdata_reg(periph_rdata[g]),
         .held_reg(held_vec[g])
      );
   end

   // -----------------------------------------------------------------
   // Dropped-write record
   // -----------------------------------------------------------------

   // dropped writes seen
   // A write refused in the same cycle as the clear still leaves its mark
   wire [NP-1:0] drop_evt = periph_we_req & (off_vec | held_vec);
   assign dropped_next = (dropped_reg & ~drop_clr) | drop_evt;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dropped_reg <= '0;
      end else begin
         dropped_reg <= dropped_next;
      end
   end

   // -----------------------------------------------------------------
   // Read mux and answer
   // -----------------------------------------------------------------

   // Held and dropped words are wider than a byte but still start at bit 0
   wire [31:0] held_word = {{(32-NP){1'b0}}, held_vec};
   wire [31:0] drop_word = {{(32-NP){1'b0}}, dropped_reg};
   wire [31:0] rd_word = hit_d0 ? lane0(block_disable_0_reg) :
                         hit_d1 ? lane0(block_disable_1_reg) :
                         hit_d2 ? lane0(block_disable_2_reg) :
                         hit_d3 ? lane0(block_disable_3_reg) :
                         hit_held ? held_word :
                         hit_drop ? drop_word : 32'h00000000;

   // Read data keeps its value until the next taken read request
   assign wb_dat_r_next = (take & ~wb_we) ? rd_word : wb_dat_r;
   assign wb_ack_next = take & mapped;
   assign wb_err_next = take & ~mapped;

   // Answer one cycle after the request is first seen, then drop it
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wb_ack <= 1'b0;
         wb_err <= 1'b0;
         wb_dat_r <= 32'h00000000;
      end else begin
         wb_ack <= wb_ack_next;
         wb_err <= wb_err_next;
         wb_dat_r <= wb_dat_r_next;
      end
   end

endmodule // pbg_top

//--- design/pbg_map.svh
`ifndef PBG_MAP_SVH
`define PBG_MAP_SVH

// -----------------------------------------------------------------
// Register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define PBG_IDX_DISABLE_0 16'hf028
`define PBG_IDX_DISABLE_1 16'hf029
`define PBG_IDX_DISABLE_2 16'hf02a
`define PBG_IDX_DISABLE_3 16'hf02b
`define PBG_IDX_HELD 16'hf030
`define PBG_IDX_DROPPED 16'hf031

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define PBG_D0_TIMER_ZERO 0
`define PBG_D0_TIMER_ONE 1
`define PBG_D0_TIMER_TWO 2
`define PBG_D0_TIMER_THREE 3
`define PBG_D1_PWM 0
`define PBG_D1_KHZ_TIMER 4
`define PBG_D1_CAPTURE 6
`define PBG_D2_SYNC_SERIAL 0
`define PBG_D2_UART 2
`define PBG_D2_I2C 7
`define PBG_D3_BUZZER 0

// -----------------------------------------------------------------
// Reset values, sizes and timing counts
// -----------------------------------------------------------------
`define PBG_DISABLE_RST 8'h00
`define PBG_NUM_PERIPH 11
`define PBG_WAKE_CYCLES 2

`endif

//--- design/pbg_pkg.sv
package pbg_pkg;

   // Gate sequencer states of one peripheral
   typedef enum logic [1:0] {
      PBG_RUN,
      PBG_STOPPING,
      PBG_STOPPED,
      PBG_WAKING
   } pbg_gate_state_t;

   // Position of each peripheral in the gate vectors
   typedef enum logic [3:0] {
      PBG_P_TIMER_ZERO,
      PBG_P_TIMER_ONE,
      PBG_P_TIMER_TWO,
      PBG_P_TIMER_THREE,
      PBG_P_CAPTURE,
      PBG_P_KHZ_TIMER,
      PBG_P_PWM,
      PBG_P_I2C,
      PBG_P_UART,
      PBG_P_SYNC_SERIAL,
      PBG_P_BUZZER
   } pbg_periph_t;

endpackage

//--- design/pbg_gate.sv
`timescale 1ns/1ns
`include "pbg_map.svh"

module pbg_gate
   import pbg_pkg::*;
#(
   parameter int WAKE_CYC = `PBG_WAKE_CYCLES
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic off,
   input wire logic we_req,
   input wire logic [7:0] rdata_raw,
   input wire logic [7:0] rdata_init,
   output logic clk_en_reg,
   output logic rst_n_reg,
   output logic we_reg,
   output logic [7:0] rdata_reg,
   output logic held_reg
);

   localparam int CW = $clog2(WAKE_CYC + 1);

   pbg_gate_state_t state_reg, state_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   wire run = (state_reg == PBG_RUN);

   // -----------------------------------------------------------------
   // Sequencer: reset goes on before the clock stops, and the clock
   // restarts before reset lifts, so synchronous resets see edges
   // -----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      unique case (state_reg)
         PBG_RUN: begin
            if (off) state_next = PBG_STOPPING;
         end
         PBG_STOPPING: begin
            state_next = PBG_STOPPED;
         end
         PBG_STOPPED: begin
            if (!off) begin
               state_next = PBG_WAKING;
               cnt_next = '0;
            end
         end
         PBG_WAKING: begin
            if (off) state_next = PBG_STOPPING;
            else if (cnt_reg == CW'(WAKE_CYC - 1)) state_next = PBG_RUN;
            else cnt_next = cnt_reg + 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= PBG_WAKING;
         cnt_reg <= '0;
         clk_en_reg <= 1'b1;
         rst_n_reg <= 1'b0;
         held_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         clk_en_reg <= (state_next != PBG_STOPPED);
         rst_n_reg <= (state_next == PBG_RUN);
         held_reg <= (state_next != PBG_RUN);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         we_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end else begin
         we_reg <= we_req & ~off & run;
         rdata_reg <= (off | ~run) ? rdata_init : rdata_raw;
      end
   end

endmodule // pbg_gate

//--- sim/pbg_top_assertions.sv
`timescale 1ns/1ns
`include "pbg_map.svh"

module pbg_top_assertions #(
   parameter int ADDR_W = 18,
   parameter int NP = `PBG_NUM_PERIPH
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_ack,
   input wire logic wb_err,
   input wire logic [NP-1:0] periph_we_req,
   input wire logic [NP-1:0][7:0] periph_rdata_init,
   input wire logic [NP-1:0] periph_clk_en,
   input wire logic [NP-1:0] periph_rst_n,
   input wire logic [NP-1:0] periph_we,
   input wire logic [NP-1:0][7:0] periph_rdata
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic live_reg;
   logic rd_bad;
   logic [NP-1:0][7:0] init_reg;
   // Skip the first edge after reset, when read data still shows its reset zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         live_reg <= 1'b0;
      end else begin
         live_reg <= 1'b1;
      end
   end
   // Read data of a held unit lags its initial value by one edge
   always_ff @(posedge clk) begin
      init_reg <= periph_rdata_init;
   end
   always_comb begin
      rd_bad = 1'b0;
      for (int i = 0; i < NP; i++) begin
         if (!periph_rst_n[i] && periph_rdata[i] != init_reg[i]) begin
            rd_bad = 1'b1;
         end
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_ack_pulse; wb_ack |=> !wb_ack; endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack held longer than one cycle");
   property p_answer; wb_cyc && wb_stb && !wb_ack && !wb_err |=> wb_ack ^ wb_err; endproperty
   a_answer: assert property (p_answer)
      else $error("bus request not answered in one cycle");
   property p_stop_in_reset; (~periph_clk_en & periph_rst_n) == '0; endproperty
   a_stop_in_reset: assert property (p_stop_in_reset)
      else $error("clock stopped on a unit out of reset");
   property p_stop_order;
      ($past(periph_clk_en) & ~periph_clk_en & $past(periph_rst_n)) == '0;
   endproperty
   a_stop_order: assert property (p_stop_order)
      else $error("clock stopped before reset was applied");
   property p_wake; (~$past(periph_rst_n) & periph_rst_n & ~$past(periph_clk_en)) == '0;
   endproperty
   a_wake: assert property (p_wake)
      else $error("reset released without a running clock");
   property p_we_req; (periph_we & ~$past(periph_we_req)) == '0; endproperty
   a_we_req: assert property (p_we_req)
      else $error("write strobe without a request");
   property p_we_run; (periph_we & ~periph_rst_n) == '0; endproperty
   a_we_run: assert property (p_we_run)
      else $error("write passed to a held unit");
   property p_rdata_init; live_reg |-> !rd_bad; endproperty
   a_rdata_init: assert property (p_rdata_init)
      else $error("held unit read data is not its initial value");
   c_err: cover property (wb_err);
   c_gate: cover property (periph_clk_en != '1);
   c_write: cover property (periph_we != '0);
endmodule // pbg_top_assertions

bind pbg_top pbg_top_assertions #(.ADDR_W(ADDR_W)) u_pbg_chk (
   .clk(clk), .arst_n(arst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_ack(wb_ack),
   .wb_err(wb_err), .periph_we_req(periph_we_req), .periph_rdata_init(periph_rdata_init),
   .periph_clk_en(periph_clk_en), .periph_rst_n(periph_rst_n), .periph_we(periph_we),
   .periph_rdata(periph_rdata)
);

//--- sim/pbg_periph_model.sv
`timescale 1ns/1ns
`include "pbg_map.svh"

module pbg_periph_model (
   input wire logic clk,
   input wire logic [`PBG_NUM_PERIPH-1:0] clk_en,
   input wire logic [`PBG_NUM_PERIPH-1:0] rst_n,
   input wire logic [`PBG_NUM_PERIPH-1:0] we,
   input wire logic [7:0] wdata,
   output logic [`PBG_NUM_PERIPH-1:0][7:0] rdata_raw,
   output logic [`PBG_NUM_PERIPH-1:0][7:0] rdata_init
);
   // ----------------------------------------
   // One register per unit
   // ----------------------------------------
   // Distinct initial values, so a wrong unit's value is caught
   always_comb begin
      for (int i = 0; i < `PBG_NUM_PERIPH; i++) begin
         rdata_init[i] = 8'h30 + 8'(i);
      end
   end
   // reset overrides; a write with the clock stopped is lost
   always_ff @(posedge clk) begin
      for (int i = 0; i < `PBG_NUM_PERIPH; i++) begin
         if (!rst_n[i]) begin
            rdata_raw[i] <= rdata_init[i];
         end else if (clk_en[i] && we[i]) begin
            rdata_raw[i] <= wdata;
         end
      end
   end
endmodule // pbg_periph_model

//--- sim/testbench.sv
`timescale 1ns/1ns
`include "pbg_map.svh"
`define CHK(a, b) begin \
   n_compared++; \
   if ((a) !== (b)) begin \
      error_cnt++; \
      $display("mismatch at %0t got %h expected %h", $time, (a), (b)); \
   end \
end

module testbench;
   localparam int NP = `PBG_NUM_PERIPH;
   localparam logic [NP-1:0] ONES = '1;
   localparam logic [15:0] RIDX [NP] = '{16'hf028, 16'hf028, 16'hf028, 16'hf028,
      16'hf029, 16'hf029, 16'hf029, 16'hf02a, 16'hf02a, 16'hf02a, 16'hf02b};
   localparam int RBIT [NP] = '{0, 1, 2, 3, 6, 4, 0, 7, 2, 0, 0};
   localparam logic [7:0] SPARE [4] = '{8'hf0, 8'hae, 8'h7a, 8'hfe};
   logic clk = 1'b0;
   logic arst_n, wb_cyc, wb_stb, wb_we, wb_ack, wb_err, e, hit_clr;
   logic [17:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_dat_w, wb_dat_r, rd;
   logic [NP-1:0] we_req, clk_en, rst_n, pwe, we_hits;
   logic [NP-1:0][7:0] raw, init, prd;
   logic [7:0] wdata;
   int error_cnt = 0;
   int n_compared = 0;

   always #20 clk = ~clk;
   // Strobes reaching units since the last poke
   always @(posedge clk) we_hits <= hit_clr ? '0 : (we_hits | pwe);

   pbg_top #(.ADDR_W(18), .WAKE_CYC(2)) dut (
      .clk(clk), .arst_n(arst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
      .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
      .wb_ack(wb_ack), .wb_err(wb_err), .periph_we_req(we_req), .periph_rdata_raw(raw),
      .periph_rdata_init(init), .periph_clk_en(clk_en), .periph_rst_n(rst_n),
      .periph_we(pwe), .periph_rdata(prd)
   );
   pbg_periph_model u_far (
      .clk(clk), .clk_en(clk_en), .rst_n(rst_n), .we(pwe), .wdata(wdata),
      .rdata_raw(raw), .rdata_init(init)
   );

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Classic cycle; the request stands until ack or err is sampled
   task automatic wb_go(input logic [15:0] idx, input logic w, input logic [7:0] d,
         input logic [3:0] sel);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= {idx, 2'b00};
      wb_sel <= sel;
      wb_dat_w <= {24'h0, d};
      do begin
         @(posedge clk);
         n++;
      end while ((wb_ack | wb_err) !== 1'b1 && n < 40);
      if (n >= 40) begin
         error_cnt++;
         final_report();
      end
      rd = wb_dat_r;
      e = wb_err;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   // One-cycle register write request into unit p, then let read data settle
   task automatic poke(input int p, input logic [7:0] d);
      @(posedge clk);
      wdata <= d;
      we_req <= NP'(1) << p;
      hit_clr <= 1'b1;
      @(posedge clk);
      we_req <= '0;
      hit_clr <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   initial begin
      arst_n = 1'b0;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = '0;
      wb_sel = 4'h0;
      wb_dat_w = '0;
      we_req = '0;
      hit_clr = 1'b1;
      wdata = 8'h00;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      `CHK(clk_en, ONES)
      `CHK(rst_n, ONES)
      for (int r = 0; r < 4; r++) begin
         wb_go(16'hf028 + 16'(r), 1'b0, 8'h00, 4'h1);
         `CHK(rd, 32'h0)
      end
      wb_go(16'h0100, 1'b0, 8'h00, 4'h1);
      `CHK(e, 1'b1)
      $display("test reset_values done");
      // Each unit alone: gate, refuse writes, show initial value, then wake
      for (int p = 0; p < NP; p++) begin
         wb_go(RIDX[p], 1'b1, 8'(1 << RBIT[p]), 4'h1);
         repeat (3) @(posedge clk);
         `CHK(clk_en, ~(NP'(1) << p))
         `CHK(rst_n, ~(NP'(1) << p))
         poke(p, 8'hc3);
         `CHK(we_hits, '0)
         `CHK(prd[p], 8'h30 + 8'(p))
         wb_go(RIDX[p], 1'b0, 8'h00, 4'h1);
         `CHK(rd, 32'(1 << RBIT[p]))
         wb_go(RIDX[p], 1'b1, 8'h00, 4'h1);
         repeat (5) @(posedge clk);
         `CHK(rst_n, ONES)
         poke(p, 8'h96);
         `CHK(prd[p], 8'h96)
      end
      $display("test gate_table done");
      // Spare bits are plain storage and gate nothing
      for (int r = 0; r < 4; r++) begin
         wb_go(16'hf028 + 16'(r), 1'b1, SPARE[r], 4'h1);
         repeat (3) @(posedge clk);
         `CHK(rst_n, ONES)
         wb_go(16'hf028 + 16'(r), 1'b0, 8'h00, 4'h1);
         `CHK(rd, {24'h0, SPARE[r]})
      end
      wb_go(16'hf028, 1'b1, 8'h0f, 4'he);
      wb_go(16'hf028, 1'b0, 8'h00, 4'h1);
      `CHK(rd, 32'hf0)
      `CHK(rst_n, ONES)
      $display("test spare_bits done");
      final_report();
   end
endmodule // testbench
